// ---- shared/ccs_params.svh ----
// Constants for the cycle-type, suspend and reset sequencing block
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH
// All timing figures are in double-rate clock periods; clk_in is that clock
`define CCS_DOUBLE_RATE_CLOCK_MHZ 40
`define CCS_CLK_MHZ 40
`define CCS_RESET_MIN_PERIODS 15
`define CCS_RESET_TEST_PERIODS 80
`define CCS_INIT_PERIODS 400
`define CCS_SELFTEST_EXP 20
`define CCS_SELFTEST_EXTRA 60
// Cycle definition codes as {mem_io, data_ctl, write_read, lock_n}
`define CCS_CODE_INTA 4'h0
`define CCS_CODE_IO_RD 4'h5
`define CCS_CODE_IO_WR 4'h7
`define CCS_CODE_CODE_RD 4'h9
`define CCS_CODE_HALT 4'hB
`define CCS_CODE_LK_RD 4'hC
`define CCS_CODE_DATA_RD 4'hD
`define CCS_CODE_LK_WR 4'hE
`define CCS_CODE_DATA_WR 4'hF
`define CCS_BE_HALT 4'hB
`define CCS_BE_SHUTDOWN 4'hE
`define CCS_ESC_CTRL_ADDR 32'h8000_00F8
`define CCS_ESC_DATA_ADDR 32'h8000_00FC
`define CCS_FETCH_ADDR 24'hFF_FFF0
`define CCS_ACC_PASS 32'h0000_0000
`endif

// ---- shared/ccs_pkg.sv ----
// Types for the cycle-type, suspend and reset sequencing block
package ccs_pkg;
  typedef enum logic [3:0] {
    CCS_K_INTA = 4'h0, CCS_K_IO_RD = 4'h1, CCS_K_IO_WR = 4'h2, CCS_K_CODE_RD = 4'h3,
    CCS_K_LK_RD = 4'h4, CCS_K_DATA_RD = 4'h5, CCS_K_LK_WR = 4'h6, CCS_K_DATA_WR = 4'h7,
    CCS_K_HALT = 4'h8, CCS_K_SHUTDOWN = 4'h9, CCS_K_ESC_OP = 4'hA, CCS_K_ESC_DATA = 4'hB
  } ccs_kind_e;
  typedef struct packed {
    logic mem_io;
    logic data_ctl;
    logic write_read;
    logic lock_n;
  } ccs_cycle_def_s;
  typedef struct packed {
    ccs_kind_e kind;
    logic [29:0] upper_addr;
    logic [3:0] be_n;
    logic pipelined;
  } ccs_bus_req_s;
endpackage

// ---- core/ccs_cycle_enc.sv ----
// Maps a requested cycle kind to its definition code, address and byte enables
`timescale 1ns/1ps
`include "ccs_params.svh"
module ccs_cycle_enc (
  input wire ccs_pkg::ccs_bus_req_s req_in,
  output ccs_pkg::ccs_cycle_def_s def_out,
  output logic [29:0] addr_out,
  output logic [3:0] be_n_out
);
  localparam logic [31:0] ESC_CTRL = `CCS_ESC_CTRL_ADDR;
  localparam logic [31:0] ESC_DATA = `CCS_ESC_DATA_ADDR;
  logic [3:0] code;

  always_comb begin
    addr_out = req_in.upper_addr;
    be_n_out = req_in.be_n;
    unique case (req_in.kind)
      ccs_pkg::CCS_K_INTA: code = `CCS_CODE_INTA;
      ccs_pkg::CCS_K_IO_RD: code = `CCS_CODE_IO_RD;
      ccs_pkg::CCS_K_IO_WR: code = `CCS_CODE_IO_WR;
      ccs_pkg::CCS_K_CODE_RD: code = `CCS_CODE_CODE_RD;
      ccs_pkg::CCS_K_LK_RD: code = `CCS_CODE_LK_RD;
      ccs_pkg::CCS_K_DATA_RD: code = `CCS_CODE_DATA_RD;
      ccs_pkg::CCS_K_LK_WR: code = `CCS_CODE_LK_WR;
      ccs_pkg::CCS_K_DATA_WR: code = `CCS_CODE_DATA_WR;
      ccs_pkg::CCS_K_HALT: begin
        code = `CCS_CODE_HALT;
        addr_out = 30'h0000_0000;
        be_n_out = `CCS_BE_HALT;
      end
      ccs_pkg::CCS_K_SHUTDOWN: begin
        code = `CCS_CODE_HALT;
        addr_out = 30'h0000_0000;
        be_n_out = `CCS_BE_SHUTDOWN;
      end
      ccs_pkg::CCS_K_ESC_OP: begin
        code = `CCS_CODE_IO_WR;
        addr_out = ESC_CTRL[31:2];
      end
      ccs_pkg::CCS_K_ESC_DATA: begin
        code = req_in.kind == ccs_pkg::CCS_K_ESC_DATA && req_in.be_n[3] ? `CCS_CODE_IO_RD : `CCS_CODE_IO_WR;
        addr_out = ESC_DATA[31:2];
      end
      // Unused kind codes fall back to a plain data read
      default: code = `CCS_CODE_DATA_RD;
    endcase
    def_out = code;
  end
endmodule

// ---- core/ccs_top.sv ----
// Cycle-type outputs, suspend handshake and reset sequencing of the processor
`timescale 1ns/1ps
`include "ccs_params.svh"
module ccs_top #(
  parameter int unsigned SELFTEST_CLKS = (32'd1 << `CCS_SELFTEST_EXP) + `CCS_SELFTEST_EXTRA,
  parameter logic [31:0] FAULT_CODE = 32'h0000_0001 // Arbitrary nonzero fault signature
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic reset_in,
  input wire logic busy_n_in,
  input wire logic suspend_request_n_in,
  input wire logic suspend_request_n_enable_in,
  input wire logic halt_exec_in,
  input wire logic core_drained_in,
  input wire logic hold_in,
  input wire logic float_in,
  input wire logic nmi_in,
  input wire logic maskable_irq_in,
  input wire logic irq_enable_in,
  input wire logic mgmt_irq_n_in,
  input wire logic selftest_fail_in,
  input wire logic req_valid_in,
  input wire ccs_pkg::ccs_bus_req_s req_in,
  input wire logic ready_n_in,
  output logic req_ready_out,
  output logic cycle_done_out,
  output ccs_pkg::ccs_cycle_def_s def_out,
  output logic def_oe_out,
  output logic address_strobe_n_out,
  output logic [29:0] upper_address_lines_out,
  output logic [3:0] byte_enables_n_out,
  output logic addr_oe_out,
  output logic data_lines_oe_out,
  output logic hold_ack_out,
  output logic mgmt_strobe_n_out,
  output logic suspend_ack_n_out,
  output logic suspend_ack_oe_out,
  output logic core_clk_en_out,
  output logic phase2_out,
  output logic selftest_active_out,
  output logic init_active_out,
  output logic fetch_start_out,
  output logic [23:0] fetch_addr_out,
  output logic [31:0] accumulator_reg_out,
  output logic nmi_take_out,
  output logic maskable_irq_take_out,
  output logic smi_take_out
);
  localparam int unsigned CLK_PER_PERIOD = `CCS_CLK_MHZ / `CCS_DOUBLE_RATE_CLOCK_MHZ;
  localparam int unsigned INIT_CLKS = `CCS_INIT_PERIODS * CLK_PER_PERIOD;
  localparam int unsigned TEST_RST_CLKS = `CCS_RESET_TEST_PERIODS * CLK_PER_PERIOD;
  // One counter serves both the self-test and the initialisation countdown
  localparam int CW = $clog2((SELFTEST_CLKS > INIT_CLKS ? SELFTEST_CLKS : INIT_CLKS) + 1);

  if (SELFTEST_CLKS < 2 || CLK_PER_PERIOD != 1 || FAULT_CODE == `CCS_ACC_PASS) begin
    $error("ccs_top: unsupported parameter values");
  end

  typedef enum logic [5:0] {
    S_RST = 6'b00_0001, S_TEST = 6'b00_0010, S_INIT = 6'b00_0100,
    S_RUN = 6'b00_1000, S_DRAIN = 6'b01_0000, S_SUSPEND_REQUEST_N = 6'b10_0000
  } ccs_seq_e;
  typedef enum logic [3:0] {
    B_IDLE = 4'b0001, B_T1 = 4'b0010, B_T2 = 4'b0100, B_HOLD = 4'b1000
  } ccs_bus_e;

  ccs_seq_e seq_r, seq_nxt;
  ccs_bus_e bus_r, bus_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [6:0] rst_len_r, rst_len_nxt;
  logic reset_d_r, busy_at_fall_r, fault_r, fault_nxt;
  logic phase_r, phase_nxt;
  logic halt_mode_r, halt_mode_nxt, halt_pend_r, halt_pend_nxt;
  logic nmi_d_r, nmi_lat_r, nmi_lat_nxt, maskable_irq_lat_r, maskable_irq_lat_nxt, smi_lat_r, smi_lat_nxt;
  logic [31:0] acc_r, acc_nxt;
  logic fetch_r, fetch_nxt, nmi_tk_r, nmi_tk_nxt, maskable_irq_tk_r, maskable_irq_tk_nxt, smi_tk_r, smi_tk_nxt;
  ccs_pkg::ccs_bus_req_s cur_r, cur_nxt, enc_req;
  ccs_pkg::ccs_cycle_def_s enc_def;
  logic [29:0] enc_addr;
  logic [3:0] enc_be;
  ccs_pkg::ccs_cycle_def_s pin_def_r, pin_def_nxt;
  logic [29:0] pin_addr_r, pin_addr_nxt;
  logic [3:0] pin_be_r, pin_be_nxt;
  logic pin_ads_n_r, pin_ads_n_nxt, pin_float_r, pin_float_nxt, pin_hold_ack_out_r, pin_hold_ack_out_nxt;
  logic pin_suspend_request_n_n_r, pin_suspend_request_n_n_nxt, lock_hold_r, lock_hold_nxt;
  logic nmi_rise, bus_idle, take, suspend_request_n_wake, halt_wake;

  ccs_cycle_enc u_enc (
    .req_in(enc_req),
    .def_out(enc_def),
    .addr_out(enc_addr),
    .be_n_out(enc_be)
  );

  assign nmi_rise = nmi_in & ~nmi_d_r;
  // a taken request is encoded at once, so pins are valid with the strobe
  assign take = phase_r && !reset_in && bus_r == B_IDLE && !hold_in && req_valid_in &&
                (seq_r == S_RUN || seq_r == S_DRAIN);
  assign enc_req = take ? req_in : cur_r;
  assign bus_idle = (bus_r == B_IDLE) && !req_valid_in;
  // request suspend keeps watching the request, halt suspend does not
  assign suspend_request_n_wake = !halt_mode_r && suspend_request_n_in;
  // halt suspend exits on NMI or unmasked maskable interrupt
  assign halt_wake = halt_mode_r && (nmi_rise || (maskable_irq_in && irq_enable_in));

  // Reset sequence, phase tracking and suspend control
  always_comb begin
    seq_nxt = seq_r;
    cnt_nxt = cnt_r;
    fault_nxt = fault_r;
    acc_nxt = acc_r;
    halt_mode_nxt = halt_mode_r;
    halt_pend_nxt = halt_pend_r | halt_exec_in;
    fetch_nxt = 1'b0;
    nmi_tk_nxt = 1'b0;
    maskable_irq_tk_nxt = 1'b0;
    smi_tk_nxt = 1'b0;
    nmi_lat_nxt = nmi_lat_r;
    maskable_irq_lat_nxt = maskable_irq_lat_r;
    smi_lat_nxt = smi_lat_r;
    rst_len_nxt = rst_len_r;
    // phase two is the second edge after reset falls
    phase_nxt = ~phase_r;
    unique case (seq_r)
      S_RST: begin
        // busy low at release requests self-test
        if (!reset_in) begin
          if (!busy_at_fall_r) begin
            seq_nxt = S_TEST;
            cnt_nxt = CW'(SELFTEST_CLKS - 1);
            // A short reset before self-test is reported as a fault
            fault_nxt = rst_len_r < 7'(TEST_RST_CLKS);
          end else begin
            seq_nxt = S_INIT;
            cnt_nxt = CW'(INIT_CLKS - 1);
          end
        end
      end
      S_TEST: begin
        if (selftest_fail_in) begin
          fault_nxt = 1'b1;
        end
        if (cnt_r == '0) begin
          acc_nxt = fault_r || selftest_fail_in ? FAULT_CODE : `CCS_ACC_PASS;
          seq_nxt = S_INIT;
          cnt_nxt = CW'(INIT_CLKS - 1);
        end else begin
          cnt_nxt = cnt_r - CW'(1);
        end
      end
      S_INIT: begin
        if (cnt_r == '0) begin
          // first fetch from the reset vector
          seq_nxt = S_RUN;
          fetch_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - CW'(1);
        end
      end
      S_RUN: begin
        if (suspend_request_n_enable_in && !suspend_request_n_in) begin
          seq_nxt = S_DRAIN;
          halt_mode_nxt = 1'b0;
        end else if (suspend_request_n_enable_in && halt_pend_r) begin
          seq_nxt = S_DRAIN;
          halt_mode_nxt = 1'b1;
        end
      end
      S_DRAIN: begin
        // drain work and wait for coprocessor idle
        if (core_drained_in && bus_idle && busy_n_in) begin
          seq_nxt = S_SUSPEND_REQUEST_N;
          halt_pend_nxt = halt_exec_in;
          nmi_lat_nxt = 1'b0;
          maskable_irq_lat_nxt = 1'b0;
          smi_lat_nxt = 1'b0;
        end
      end
      S_SUSPEND_REQUEST_N: begin
        // latch interrupts during request suspend, set wins
        if (!halt_mode_r) begin
          nmi_lat_nxt = nmi_lat_r | nmi_rise;
          maskable_irq_lat_nxt = maskable_irq_lat_r | maskable_irq_in;
          smi_lat_nxt = smi_lat_r | ~mgmt_irq_n_in;
        end
        if (suspend_request_n_wake) begin
          seq_nxt = S_RUN;
          nmi_tk_nxt = nmi_lat_r | nmi_rise;
          maskable_irq_tk_nxt = maskable_irq_lat_r | maskable_irq_in;
          smi_tk_nxt = smi_lat_r | ~mgmt_irq_n_in;
        end else if (halt_wake) begin
          seq_nxt = S_RUN;
          nmi_tk_nxt = nmi_rise;
          maskable_irq_tk_nxt = ~nmi_rise;
        end
      end
      default: seq_nxt = S_RST;
    endcase
    if (reset_in) begin
      seq_nxt = S_RST;
      phase_nxt = 1'b1;
      halt_pend_nxt = 1'b0;
      rst_len_nxt = rst_len_r == 7'(TEST_RST_CLKS) ? rst_len_r : rst_len_r + 7'd1;
      if (!reset_d_r) begin
        rst_len_nxt = 7'd1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seq_r <= S_RST;
      cnt_r <= '0;
      fault_r <= 1'b0;
      acc_r <= 32'h0000_0000;
      halt_mode_r <= 1'b0;
      halt_pend_r <= 1'b0;
      fetch_r <= 1'b0;
      nmi_tk_r <= 1'b0;
      maskable_irq_tk_r <= 1'b0;
      smi_tk_r <= 1'b0;
      nmi_lat_r <= 1'b0;
      maskable_irq_lat_r <= 1'b0;
      smi_lat_r <= 1'b0;
      rst_len_r <= 7'h00;
      phase_r <= 1'b1;
      reset_d_r <= 1'b0;
      busy_at_fall_r <= 1'b1;
      nmi_d_r <= 1'b0;
    end else begin
      seq_r <= seq_nxt;
      cnt_r <= cnt_nxt;
      fault_r <= fault_nxt;
      acc_r <= acc_nxt;
      halt_mode_r <= halt_mode_nxt;
      halt_pend_r <= halt_pend_nxt;
      fetch_r <= fetch_nxt;
      nmi_tk_r <= nmi_tk_nxt;
      maskable_irq_tk_r <= maskable_irq_tk_nxt;
      smi_tk_r <= smi_tk_nxt;
      nmi_lat_r <= nmi_lat_nxt;
      maskable_irq_lat_r <= maskable_irq_lat_nxt;
      smi_lat_r <= smi_lat_nxt;
      rst_len_r <= rst_len_nxt;
      phase_r <= phase_nxt;
      reset_d_r <= reset_in;
      busy_at_fall_r <= reset_in ? busy_n_in : busy_at_fall_r;
      nmi_d_r <= nmi_in;
    end
  end

  // Bus state and pin drive; T states end on phase two
  always_comb begin
    bus_nxt = bus_r;
    cur_nxt = cur_r;
    lock_hold_nxt = lock_hold_r;
    if (phase_r) begin
      unique case (bus_r)
        B_IDLE: begin
          if (hold_in) begin
            bus_nxt = B_HOLD;
          end else if (take) begin
            cur_nxt = req_in;
            bus_nxt = B_T1;
            lock_hold_nxt = req_in.pipelined;
          end
        end
        B_T1: begin
          bus_nxt = B_T2;
          lock_hold_nxt = 1'b0;
        end
        // ready from the system ends every cycle
        B_T2: begin
          if (!ready_n_in) begin
            bus_nxt = B_IDLE;
          end
        end
        B_HOLD: begin
          if (!hold_in) begin
            bus_nxt = B_IDLE;
          end
        end
        default: bus_nxt = B_IDLE;
      endcase
    end
    pin_def_nxt = enc_def;
    pin_addr_nxt = enc_addr;
    pin_be_nxt = enc_be;
    // strobe asserted in T1 with the definition
    pin_ads_n_nxt = bus_nxt != B_T1;
    // non-pipelined lock valid with the others
    // pipelined lock held back through T1, valid from T2
    if (lock_hold_nxt) begin
      pin_def_nxt.lock_n = 1'b1;
    end
    // float in hold or float state
    pin_float_nxt = bus_nxt == B_HOLD || float_in;
    pin_hold_ack_out_nxt = bus_nxt == B_HOLD;
    pin_suspend_request_n_n_nxt = 1'b1;
    if (seq_nxt == S_SUSPEND_REQUEST_N) begin
      pin_def_nxt = 4'b0101;
      pin_addr_nxt = '1;
      pin_be_nxt = 4'h0;
      pin_ads_n_nxt = 1'b1;
      pin_float_nxt = 1'b0;
      pin_hold_ack_out_nxt = 1'b0;
      pin_suspend_request_n_n_nxt = 1'b0;
    end
    // reset aborts the bus cycle and sets reset pin states
    if (reset_in) begin
      bus_nxt = B_IDLE;
      pin_def_nxt = 4'b0101;
      pin_addr_nxt = '1;
      pin_be_nxt = 4'h0;
      pin_ads_n_nxt = 1'b1;
      pin_float_nxt = 1'b0;
      pin_hold_ack_out_nxt = 1'b0;
      pin_suspend_request_n_n_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_r <= B_IDLE;
      cur_r <= '0;
      lock_hold_r <= 1'b0;
      pin_def_r <= 4'b0101;
      pin_addr_r <= 30'h3FFF_FFFF;
      pin_be_r <= 4'h0;
      pin_ads_n_r <= 1'b1;
      pin_float_r <= 1'b0;
      pin_hold_ack_out_r <= 1'b0;
      pin_suspend_request_n_n_r <= 1'b1;
    end else begin
      bus_r <= bus_nxt;
      cur_r <= cur_nxt;
      lock_hold_r <= lock_hold_nxt;
      pin_def_r <= pin_def_nxt;
      pin_addr_r <= pin_addr_nxt;
      pin_be_r <= pin_be_nxt;
      pin_ads_n_r <= pin_ads_n_nxt;
      pin_float_r <= pin_float_nxt;
      pin_hold_ack_out_r <= pin_hold_ack_out_nxt;
      pin_suspend_request_n_n_r <= pin_suspend_request_n_n_nxt;
    end
  end

  assign req_ready_out = take;
  assign cycle_done_out = bus_r == B_T2 && phase_r && !ready_n_in && !reset_in;
  assign def_out = pin_def_r;
  assign def_oe_out = ~pin_float_r;
  assign address_strobe_n_out = pin_ads_n_r;
  assign upper_address_lines_out = pin_addr_r;
  assign byte_enables_n_out = pin_be_r;
  assign addr_oe_out = ~pin_float_r;
  // Data bus floats outside write cycles, always in suspend
  assign data_lines_oe_out = (bus_r == B_T2) && cur_r.kind != ccs_pkg::CCS_K_HALT &&
                             cur_r.kind != ccs_pkg::CCS_K_SHUTDOWN && enc_def.write_read && !pin_float_r;
  assign hold_ack_out = pin_hold_ack_out_r;
  // Management strobe idles high; management cycles live elsewhere
  assign mgmt_strobe_n_out = 1'b1;
  assign suspend_ack_n_out = pin_suspend_request_n_n_r;
  assign suspend_ack_oe_out = suspend_request_n_enable_in;
  // core logic needs no input clock edges while acknowledged
  assign core_clk_en_out = phase_r && seq_r != S_SUSPEND_REQUEST_N && seq_r != S_RST;
  assign phase2_out = phase_r;
  assign selftest_active_out = seq_r == S_TEST;
  assign init_active_out = seq_r == S_INIT;
  assign fetch_start_out = fetch_r;
  assign fetch_addr_out = `CCS_FETCH_ADDR;
  assign accumulator_reg_out = acc_r;
  assign nmi_take_out = nmi_tk_r;
  assign maskable_irq_take_out = maskable_irq_tk_r;
  assign smi_take_out = smi_tk_r;
  // reset length is the system's duty; short self-test resets read as faults
endmodule

// ---- verif/ccs_checker_assertions.sv ----
// Port-level checks for the cycle-type, suspend and reset block
`timescale 1ns/1ps
module ccs_checker (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic reset_in,
  input wire logic suspend_request_n_enable_in,
  input wire logic ready_n_in,
  input wire logic req_ready_out,
  input wire logic cycle_done_out,
  input wire ccs_pkg::ccs_cycle_def_s def_out,
  input wire logic def_oe_out,
  input wire logic address_strobe_n_out,
  input wire logic [29:0] upper_address_lines_out,
  input wire logic [3:0] byte_enables_n_out,
  input wire logic data_lines_oe_out,
  input wire logic hold_ack_out,
  input wire logic mgmt_strobe_n_out,
  input wire logic suspend_ack_n_out,
  input wire logic suspend_ack_oe_out,
  input wire logic core_clk_en_out,
  input wire logic phase2_out,
  input wire logic fetch_start_out,
  input wire logic [23:0] fetch_addr_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_take_strobe: assert property (req_ready_out |=> !address_strobe_n_out)
    else $error("strobe missing after take");
  a_strobe_two: assert property ($fell(address_strobe_n_out) |=> !address_strobe_n_out ##1 address_strobe_n_out)
    else $error("strobe width wrong");
  a_code_legal: assert property (!address_strobe_n_out |-> {def_out} inside {4'h0, 4'h5, 4'h7, 4'h9, 4'hB, 4'hC,
    4'hD, 4'hE, 4'hF})
    else $error("unlisted cycle code");
  a_hold_float: assert property (hold_ack_out |-> !def_oe_out)
    else $error("definition driven in hold");
  a_ack_float: assert property (!suspend_request_n_enable_in |-> !suspend_ack_oe_out && suspend_ack_n_out)
    else $error("acknowledge driven while disabled");
  a_suspend_request_n_pins: assert property (!suspend_ack_n_out |-> address_strobe_n_out && (&upper_address_lines_out) &&
    byte_enables_n_out == 4'h0 && {def_out} == 4'h5 && !hold_ack_out && mgmt_strobe_n_out && !data_lines_oe_out)
    else $error("pin state wrong in suspend");
  a_suspend_request_n_clk: assert property (!suspend_ack_n_out |-> !core_clk_en_out)
    else $error("core clock runs in suspend");
  a_reset_pins: assert property (reset_in |=> address_strobe_n_out && {def_out} == 4'h5 && !hold_ack_out &&
    byte_enables_n_out == 4'h0 && suspend_ack_n_out)
    else $error("reset state not established");
  a_phase_sync: assert property ($fell(reset_in) |=> !phase2_out ##1 phase2_out)
    else $error("phase two misplaced after reset");
  a_fetch_addr: assert property (fetch_start_out |-> fetch_addr_out == 24'hFF_FFF0)
    else $error("wrong first fetch address");
  a_done_ready: assert property (cycle_done_out |-> !ready_n_in && address_strobe_n_out)
    else $error("cycle ended without ready in T2");
  c_take: cover property (req_ready_out);
  c_suspend: cover property ($fell(suspend_ack_n_out));
  c_fetch: cover property (fetch_start_out);
endmodule
bind ccs_top ccs_checker u_chk (.*);

// ---- verif/ccs_sys_model.sv ----
// System bus logic model: answers each cycle with ready after some wait states
`timescale 1ns/1ps
module ccs_sys_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic reset_in,
  input wire logic address_strobe_n_in,
  input wire logic cycle_done_in,
  input wire logic [3:0] wait_in,
  output logic ready_n_out
);
  logic active_r;
  logic [3:0] cnt_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      active_r <= 1'b0;
      cnt_r <= 4'h0;
      ready_n_out <= 1'b1;
    end else if (cycle_done_in || reset_in) begin
      active_r <= 1'b0;
      ready_n_out <= 1'b1;
    end else if (!address_strobe_n_in) begin
      active_r <= 1'b1;
      cnt_r <= 4'h0;
    end else if (active_r && cnt_r >= wait_in) begin
      ready_n_out <= 1'b0;
    end else if (active_r) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for the cycle-type, suspend and reset block
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned ST_CLKS = 100;
  logic clk_in = 0, rst_n_in = 0, reset_in = 1, busy_n_in = 1, suspend_request_n_in = 1, suspend_request_n_enable_in = 0;
  logic halt_exec_in = 0, core_drained_in = 1, hold_in = 0, float_in = 0, nmi_in = 0, maskable_irq_in = 0;
  logic irq_enable_in = 0, mgmt_irq_n_in = 1, selftest_fail_in = 0, req_valid_in = 0, ready_n_in, clk_stop = 0;
  ccs_pkg::ccs_bus_req_s req_in = '0;
  logic req_ready_out, cycle_done_out, def_oe_out, address_strobe_n_out, addr_oe_out, data_lines_oe_out;
  logic hold_ack_out, mgmt_strobe_n_out, suspend_ack_n_out, suspend_ack_oe_out, core_clk_en_out, phase2_out;
  logic selftest_active_out, init_active_out, fetch_start_out, nmi_take_out, maskable_irq_take_out, smi_take_out;
  ccs_pkg::ccs_cycle_def_s def_out;
  logic [29:0] upper_address_lines_out;
  logic [3:0] byte_enables_n_out, wait_n = 0;
  logic [23:0] fetch_addr_out;
  logic [31:0] accumulator_reg_out;
  int bad_count = 0, check_count = 0, n;
  // Stop gate lets the system freeze the input clock in either phase
  initial forever #12.5 if (!clk_stop) clk_in = ~clk_in;
  ccs_top #(.SELFTEST_CLKS(ST_CLKS)) uut (.*);
  ccs_sys_model u_sys (.clk_in, .rst_n_in, .reset_in, .address_strobe_n_in(address_strobe_n_out),
    .cycle_done_in(cycle_done_out), .wait_in(wait_n), .ready_n_out(ready_n_in));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic sel(input int w);
    case (w)
      0: return req_ready_out;
      1: return cycle_done_out;
      2: return fetch_start_out;
      3: return !suspend_ack_n_out;
      4: return suspend_ack_n_out;
      5: return hold_ack_out;
      6: return maskable_irq_take_out;
      default: return nmi_take_out;
    endcase
  endfunction
  // Bounded wait, n returns the cycles spent
  task wait_on(input int w, input int lim);
    for (n = 0; n < lim; n++) begin
      #1;
      if (sel(w) === 1'b1) return;
      @(negedge clk_in);
    end
    bad_count++;
    $display("Error at %0t ns: wait %0d timed out", $time, w);
    final_report();
  endtask
  task do_reset(input logic bn, input int hold);
    @(negedge clk_in);
    reset_in = 1;
    busy_n_in = bn;
    repeat (hold) @(negedge clk_in);
    reset_in = 0;
    busy_n_in = 1;
    @(negedge clk_in);
    check(selftest_active_out, !bn);
    check(init_active_out, bn);
    wait_on(2, 3000);
    check((n - (bn ? 0 : ST_CLKS)) inside {[380:420]}, 1);
  endtask
  task t_selftest;
    do_reset(0, 90);
    check(accumulator_reg_out, 32'h0000_0000);
    selftest_fail_in = 1;
    do_reset(0, 90);
    check(accumulator_reg_out != 0, 1);
    selftest_fail_in = 0;
    do_reset(0, 20);
    check(accumulator_reg_out != 0, 1);
  endtask
  task automatic bus_cycle(input int k, input logic pipe, input logic [3:0] ed, input logic [29:0] ea,
    input logic [3:0] eb);
    @(negedge clk_in);
    req_in = '{ccs_pkg::ccs_kind_e'(k), 30'h0123_4567, 4'h8, pipe};
    req_valid_in = 1;
    wait_on(0, 20);
    @(negedge clk_in);
    req_valid_in = 0;
    check(address_strobe_n_out, 0);
    check(def_out, pipe ? {ed[3:1], 1'b1} : ed);
    check(upper_address_lines_out, ea);
    check(byte_enables_n_out, eb);
    repeat (2) @(negedge clk_in);
    check(def_out, ed);
    check(data_lines_oe_out, ed[1] && ed != 4'hB);
    wait_on(1, 40);
  endtask
  task automatic t_cycles;
    logic [3:0] dt [12] = '{4'h0, 4'h5, 4'h7, 4'h9, 4'hC, 4'hD, 4'hE, 4'hF, 4'hB, 4'hB, 4'h7, 4'h5};
    for (int i = 0; i < 12; i++) begin
      wait_n = 4'(i % 3);
      bus_cycle(i, 0, dt[i], (i == 8 || i == 9) ? 30'h0 : (i == 10 ? 30'h2000_003E : (i == 11 ? 30'h2000_003F :
        30'h0123_4567)), i == 8 ? 4'hB : (i == 9 ? 4'hE : 4'h8));
    end
    bus_cycle(4, 1, 4'hC, 30'h0123_4567, 4'h8);
  endtask
  task t_hold;
    hold_in = 1;
    wait_on(5, 20);
    check(def_oe_out, 0);
    check(addr_oe_out, 0);
    hold_in = 0;
    float_in = 1;
    repeat (3) @(negedge clk_in);
    check(def_oe_out, 0);
    float_in = 0;
    repeat (3) @(negedge clk_in);
    check(def_oe_out, 1);
  endtask
  task t_suspend_request_n_off;
    suspend_request_n_in = 0;
    repeat (20) @(negedge clk_in);
    check(suspend_ack_n_out, 1);
    check(suspend_ack_oe_out, 0);
    bus_cycle(5, 0, 4'hD, 30'h0123_4567, 4'h8);
    suspend_request_n_in = 1;
  endtask
  task t_suspend_request_n_req;
    @(negedge clk_in);
    suspend_request_n_enable_in = 1;
    core_drained_in = 0;
    busy_n_in = 0;
    suspend_request_n_in = 0;
    repeat (10) @(negedge clk_in);
    check(suspend_ack_n_out, 1);
    core_drained_in = 1;
    repeat (10) @(negedge clk_in);
    check(suspend_ack_n_out, 1);
    busy_n_in = 1;
    wait_on(3, 10);
    maskable_irq_in = 1;
    irq_enable_in = 1;
    mgmt_irq_n_in = 0;
    repeat (6) @(negedge clk_in);
    maskable_irq_in = 0;
    mgmt_irq_n_in = 1;
    check(suspend_ack_n_out, 0);
    clk_stop = 1;
    #300;
    clk_stop = 0;
    @(negedge clk_in);
    suspend_request_n_in = 1;
    wait_on(4, 4);
    check(maskable_irq_take_out, 1);
    check(smi_take_out, 1);
  endtask
  task t_suspend_request_n_halt;
    irq_enable_in = 0;
    halt_exec_in = 1;
    @(negedge clk_in);
    halt_exec_in = 0;
    wait_on(3, 20);
    suspend_request_n_in = 0;
    repeat (4) @(negedge clk_in);
    suspend_request_n_in = 1;
    maskable_irq_in = 1;
    repeat (6) @(negedge clk_in);
    check(suspend_ack_n_out, 0);
    nmi_in = 1;
    wait_on(7, 12);
    nmi_in = 0;
    maskable_irq_in = 0;
    @(negedge clk_in);
    check(suspend_ack_n_out, 1);
    irq_enable_in = 1;
    halt_exec_in = 1;
    @(negedge clk_in);
    halt_exec_in = 0;
    wait_on(3, 20);
    maskable_irq_in = 1;
    wait_on(6, 12);
    maskable_irq_in = 0;
  endtask
  task rst_mid;
    @(negedge clk_in);
    reset_in = 1;
    repeat (2) @(negedge clk_in);
    check(def_out, 4'h5);
    check(suspend_ack_n_out, 1);
    do_reset(1, 20);
  endtask
  task t_abort;
    wait_n = 4'hF;
    req_in = '{ccs_pkg::CCS_K_DATA_WR, 30'h0123_4567, 4'h8, 1'b0};
    req_valid_in = 1;
    wait_on(0, 20);
    @(negedge clk_in);
    req_valid_in = 0;
    repeat (2) @(negedge clk_in);
    rst_mid();
    halt_exec_in = 1;
    @(negedge clk_in);
    halt_exec_in = 0;
    wait_on(3, 20);
    rst_mid();
  endtask
  initial begin
    repeat (12) @(negedge clk_in);
    rst_n_in = 1;
    do_reset(1, 20);
    check(accumulator_reg_out, 32'h0000_0000);
    t_selftest();
    t_cycles();
    t_hold();
    t_suspend_request_n_off();
    t_suspend_request_n_req();
    t_suspend_request_n_halt();
    t_abort();
    final_report();
  end
endmodule
